// ==== logic/etec_pkg.sv ====
package etec_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam int AW = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_OPEN = 8'h04;
    localparam logic [7:0] OFS_CLOSE = 8'h08;
    localparam logic [7:0] OFS_HIT = 8'h0c;
    localparam logic [7:0] OFS_CMD = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_TRCNT = 8'h18;
    // Timer A, timer B, PWM unit: base + index * stride
    localparam logic [7:0] OFS_TMR_BASE = 8'h20;
    localparam logic [7:0] OFS_TMR_LAST = 8'h4c;
    localparam int TMR_IDX_LSB = 4;
    localparam int TMR_IDX_W = 2;
    localparam logic [1:0] TSUB_PRESC = 2'h0;
    localparam logic [1:0] TSUB_CMP = 2'h1;
    localparam logic [1:0] TSUB_CNT = 2'h2;
    localparam logic [1:0] TSUB_CAP = 2'h3;
    localparam int TSUB_LSB = 2;

    // ------------------------------------------------------------
    // Fields and constants
    // ------------------------------------------------------------
    localparam int NTMR = 3;
    localparam int TMR_A = 0;
    localparam int TMR_PWM = 2;
    localparam int TW = 16;
    localparam int PRESC_W = 4;
    localparam int PRESC_EXT_BIT = 4;
    localparam int CMD_RESUME = 0;
    localparam int CMD_TRCLR = 1;
    localparam int NSYNC = 7;
    localparam int NPROBE = 3;
    localparam logic [15:0] ADDR_KNOWN = 16'h2000;
    localparam int TRACE_DEPTH = 256;

    typedef struct packed {
        logic clk_ext;
        logic halt_rst;
        logic wdg_hw;
        logic [2:0] run;
        logic brk_ovf;
        logic brk_trig;
        logic filt_en;
        logic hit_mode;
    } etec_ctrl_t;

    localparam etec_ctrl_t CTRL_RST = 10'h000;

    typedef struct packed {
        logic known;
        logic [3:0] pins;
        logic [15:0] addr;
    } etec_trace_t;

    // Synchroniser lanes: timer A clock, captures, probes, trigger in
    typedef struct packed {
        logic ta_ext;
        logic cap_b;
        logic cap_a;
        logic [2:0] probe;
        logic trig_in;
    } etec_pins_t;

endpackage

// ==== logic/etec_timer.sv ====
`timescale 1ns/10ps
module etec_timer #(
    parameter int W = 16,
    parameter int PW = 4
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic run_i,
    input wire logic [PW-1:0] presc_i,
    input wire logic ext_sel_i,
    input wire logic ext_edge_i,
    input wire logic cap_lvl_i,
    input wire logic [W-1:0] cmp_i,
    output logic [W-1:0] cnt_o,
    output logic [W-1:0] cap_o,
    output logic match_o,
    output logic pwm_o
);
    logic [15:0] pre_ff, nxt_pre;
    logic [W-1:0] cnt_ff, nxt_cnt, cap_ff, nxt_cap;
    logic match_ff, nxt_match, pwm_ff, nxt_pwm, capp_ff, nxt_capp;
    logic [15:0] mask;
    logic tick;

    // ------------------------------------------------------------
    // Prescaler and free-running counter
    // ------------------------------------------------------------
    always_comb begin
        mask = 16'((17'h00001 << presc_i) - 17'h00001);
        tick = ext_sel_i ? ext_edge_i : ((pre_ff & mask) == mask);
        nxt_pre = pre_ff;
        nxt_cnt = cnt_ff;
        nxt_cap = cap_ff;
        nxt_capp = cap_lvl_i;
        nxt_match = 1'b0;
        if (run_i) begin
            nxt_pre = pre_ff + 16'h0001;
            if (tick) begin
                nxt_cnt = cnt_ff + W'(1);
                nxt_match = (cnt_ff == cmp_i);
            end
        end
        // Capture stays live: a frozen counter still gets sampled
        if (cap_lvl_i && !capp_ff) begin
            nxt_cap = cnt_ff;
        end
        nxt_pwm = (cnt_ff < cmp_i);
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pre_ff <= 16'h0000;
            cnt_ff <= '0;
            cap_ff <= '0;
            capp_ff <= 1'b0;
            match_ff <= 1'b0;
            pwm_ff <= 1'b0;
        end else begin
            pre_ff <= nxt_pre;
            cnt_ff <= nxt_cnt;
            cap_ff <= nxt_cap;
            capp_ff <= nxt_capp;
            match_ff <= nxt_match;
            pwm_ff <= nxt_pwm;
        end
    end

    assign cnt_o = cnt_ff;
    assign cap_o = cap_ff;
    assign match_o = match_ff;
    assign pwm_o = pwm_ff;

    freeze_hold_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !run_i |=> cnt_ff == $past(cnt_ff))
        else $error("counter moved while frozen");

endmodule

// ==== logic/etec_core.sv ====
// Overview of operation
// - Trigger-in rising edge halts after instruction
// - Only hardware events drive trigger; trace takes every access until full, unless halted or filtered
// - Open address access starts event window
// - Close address access ends event window
// - Single-address event active only on hits
// - Trigger output mode: window or single hit
// - Pins traced at or above 2000H, else unknown
// - Timers: 16-bit counter, prescaler, compare, capture
// - Per-timer option: freeze or run at break
// - Timer A external clock counts only while timer A runs
// - PWM unit has same freeze option
// - Watchdog enabled by software or hardware
// - Halt with watchdog on resets when enabled
// - CPU clock: on-board 16 MHz or external
// - Trace filter gates recording by same events
// - Break on trace overflow halts when full
`timescale 1ns/10ps
module etec_core #(
    parameter int DEPTH = etec_pkg::TRACE_DEPTH
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [15:0] cpu_addr_i,
    input wire logic cpu_access_i,
    input wire logic instr_done_i,
    input wire logic halt_instr_i,
    input wire logic wdg_sw_enable_i,
    input wire logic break_i,
    input wire logic trigger_input_pin_i,
    input wire logic [2:0] probe_i,
    input wire logic timer_a_external_clock_i,
    input wire logic [1:0] capture_i,
    output logic trigger_output_pin_o,
    output logic trace_valid_o,
    output etec_pkg::etec_trace_t trace_data_o,
    output logic halted_o,
    output logic chip_reset_o,
    output logic wdg_on_o,
    output logic clk_ext_sel_o,
    output logic [2:0] tmr_pwm_o,
    output logic [2:0] tmr_match_o
);
    localparam int CW = $clog2(DEPTH + 1);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [1:0] tmr_idx(input logic [7:0] a);
        logic [7:0] d;
        d = a - etec_pkg::OFS_TMR_BASE;
        return d[etec_pkg::TMR_IDX_LSB +: etec_pkg::TMR_IDX_W];
    endfunction

    function automatic logic tmr_hit(input logic [7:0] a);
        return a >= etec_pkg::OFS_TMR_BASE && a <= etec_pkg::OFS_TMR_LAST;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    etec_pkg::etec_pins_t sync1_ff, sync2_ff, sync3_ff, pins_raw;
    logic trig_rise, ta_edge;

    assign pins_raw = {timer_a_external_clock_i, capture_i[1], capture_i[0],
                       probe_i, trigger_input_pin_i};

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            sync3_ff <= '0;
        end else begin
            sync1_ff <= pins_raw;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    assign trig_rise = sync2_ff.trig_in && !sync3_ff.trig_in;
    // Edge detection never stops, but edges seen while timer A is frozen are not counted
    assign ta_edge = sync2_ff.ta_ext && !sync3_ff.ta_ext;

    // ------------------------------------------------------------
    // Register file and Avalon slave
    // ------------------------------------------------------------
    etec_pkg::etec_ctrl_t ctrl_ff, nxt_ctrl;
    logic [15:0] open_ff, nxt_open, close_ff, nxt_close, hit_ff, nxt_hit;
    logic [7:0] presc_ff [etec_pkg::NTMR], nxt_presc [etec_pkg::NTMR];
    logic [15:0] cmp_ff [etec_pkg::NTMR], nxt_cmp [etec_pkg::NTMR];
    logic [15:0] cnt_w [etec_pkg::NTMR], cap_w [etec_pkg::NTMR];
    logic [31:0] rdata_ff, nxt_rdata, rd_mux, wr_word;
    logic ack_ff, nxt_ack, req, wr_en, cmd_resume, cmd_trclr;
    logic [1:0] ti;
    logic [1:0] ts;
    logic trig_ff, win_ff, halted_ff, pend_ff;
    logic [CW-1:0] tcnt_ff;
    logic trace_full;

    assign req = avs_read_i || avs_write_i;
    assign avs_waitrequest_o = req && !ack_ff;
    assign wr_en = avs_write_i && ack_ff;
    assign ti = tmr_idx(avs_address_i);
    assign ts = avs_address_i[etec_pkg::TSUB_LSB +: 2];
    assign cmd_resume = wr_en && avs_address_i == etec_pkg::OFS_CMD
                        && avs_byteenable_i[0]
                        && avs_writedata_i[etec_pkg::CMD_RESUME];
    assign cmd_trclr = wr_en && avs_address_i == etec_pkg::OFS_CMD
                       && avs_byteenable_i[0]
                       && avs_writedata_i[etec_pkg::CMD_TRCLR];

    always_comb begin
        rd_mux = 32'h00000000;
        case (avs_address_i)
            etec_pkg::OFS_CTRL: rd_mux = 32'(ctrl_ff);
            etec_pkg::OFS_OPEN: rd_mux = 32'(open_ff);
            etec_pkg::OFS_CLOSE: rd_mux = 32'(close_ff);
            etec_pkg::OFS_HIT: rd_mux = 32'(hit_ff);
            etec_pkg::OFS_STATUS: rd_mux = 32'({trace_full, pend_ff,
                                              halted_ff, win_ff, trig_ff});
            etec_pkg::OFS_TRCNT: rd_mux = 32'(tcnt_ff);
            default: begin
                if (tmr_hit(avs_address_i)) begin
                    case (ts)
                        etec_pkg::TSUB_PRESC: rd_mux = 32'(presc_ff[ti]);
                        etec_pkg::TSUB_CMP: rd_mux = 32'(cmp_ff[ti]);
                        etec_pkg::TSUB_CNT: rd_mux = 32'(cnt_w[ti]);
                        etec_pkg::TSUB_CAP: rd_mux = 32'(cap_w[ti]);
                        default: rd_mux = 32'h00000000;
                    endcase
                end
            end
        endcase
    end

    always_comb begin
        nxt_ack = req && !ack_ff;
        nxt_rdata = (avs_read_i && !ack_ff) ? rd_mux : rdata_ff;
        nxt_ctrl = ctrl_ff;
        nxt_open = open_ff;
        nxt_close = close_ff;
        nxt_hit = hit_ff;
        nxt_presc = presc_ff;
        nxt_cmp = cmp_ff;
        wr_word = be_merge(rd_mux, avs_writedata_i, avs_byteenable_i);
        if (wr_en) begin
            case (avs_address_i)
                etec_pkg::OFS_CTRL: nxt_ctrl = wr_word[9:0];
                etec_pkg::OFS_OPEN: nxt_open = wr_word[15:0];
                etec_pkg::OFS_CLOSE: nxt_close = wr_word[15:0];
                etec_pkg::OFS_HIT: nxt_hit = wr_word[15:0];
                default: begin
                    if (tmr_hit(avs_address_i) && ts == etec_pkg::TSUB_PRESC)
                    begin
                        nxt_presc[ti] = wr_word[7:0];
                    end
                    if (tmr_hit(avs_address_i) && ts == etec_pkg::TSUB_CMP)
                    begin
                        nxt_cmp[ti] = wr_word[15:0];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            ctrl_ff <= etec_pkg::CTRL_RST;
            open_ff <= 16'h0000;
            close_ff <= 16'h0000;
            hit_ff <= 16'h0000;
            for (int i = 0; i < etec_pkg::NTMR; i++) begin
                presc_ff[i] <= 8'h00;
                cmp_ff[i] <= 16'h0000;
            end
        end else begin
            ack_ff <= nxt_ack;
            rdata_ff <= nxt_rdata;
            ctrl_ff <= nxt_ctrl;
            open_ff <= nxt_open;
            close_ff <= nxt_close;
            hit_ff <= nxt_hit;
            presc_ff <= nxt_presc;
            cmp_ff <= nxt_cmp;
        end
    end

    assign avs_readdata_o = rdata_ff;

    // ------------------------------------------------------------
    // Hardware events, trigger output and trace
    // ------------------------------------------------------------
    logic open_acc, close_acc, hit_acc, ev_active, rec, nxt_trig, nxt_win;
    logic nxt_halted, nxt_pend, nxt_tvalid, nxt_creset, wdg_sw_ff;
    logic nxt_wdg_sw, wdg_on, tvalid_ff, creset_ff, at_full;
    logic [CW-1:0] nxt_tcnt;
    etec_pkg::etec_trace_t tdata_ff, nxt_tdata;

    assign open_acc = cpu_access_i && cpu_addr_i == open_ff;
    assign close_acc = cpu_access_i && cpu_addr_i == close_ff;
    assign hit_acc = cpu_access_i && cpu_addr_i == hit_ff;
    assign trace_full = tcnt_ff == CW'(DEPTH);
    assign wdg_on = ctrl_ff.wdg_hw || wdg_sw_ff;

    always_comb begin
        // An open access wins over a close access in the same cycle
        nxt_win = open_acc || (win_ff && !close_acc);
        ev_active = ctrl_ff.hit_mode ? hit_acc : nxt_win;
        nxt_trig = ev_active;
        rec = cpu_access_i && !halted_ff && !trace_full
              && (!ctrl_ff.filt_en || ev_active);
        at_full = rec && tcnt_ff == CW'(DEPTH - 1);
        nxt_tvalid = rec;
        nxt_tdata = tdata_ff;
        nxt_tcnt = cmd_trclr ? '0 : tcnt_ff;
        if (rec) begin
            nxt_tcnt = tcnt_ff + CW'(1);
            nxt_tdata.addr = cpu_addr_i;
            // Pin lanes only exist for code at or above the boundary
            nxt_tdata.known = cpu_addr_i >= etec_pkg::ADDR_KNOWN;
            nxt_tdata.pins = nxt_tdata.known
                             ? {sync2_ff.trig_in, sync2_ff.probe} : 4'hf;
        end
        // Set wins over a resume written in the same cycle
        nxt_pend = (pend_ff && !cmd_resume)
                   || (ctrl_ff.brk_trig && trig_rise);
        nxt_halted = halted_ff && !cmd_resume;
        if (nxt_pend && instr_done_i) begin
            nxt_halted = 1'b1;
            nxt_pend = 1'b0;
        end
        if (ctrl_ff.brk_ovf && at_full) begin
            nxt_halted = 1'b1;
        end
        nxt_wdg_sw = wdg_sw_ff || wdg_sw_enable_i;
        nxt_creset = halt_instr_i && wdg_on && ctrl_ff.halt_rst;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            win_ff <= 1'b0;
            trig_ff <= 1'b0;
            tvalid_ff <= 1'b0;
            tdata_ff <= '0;
            tcnt_ff <= '0;
            pend_ff <= 1'b0;
            halted_ff <= 1'b0;
            wdg_sw_ff <= 1'b0;
            creset_ff <= 1'b0;
        end else begin
            win_ff <= nxt_win;
            trig_ff <= nxt_trig;
            tvalid_ff <= nxt_tvalid;
            tdata_ff <= nxt_tdata;
            tcnt_ff <= nxt_tcnt;
            pend_ff <= nxt_pend;
            halted_ff <= nxt_halted;
            wdg_sw_ff <= nxt_wdg_sw;
            creset_ff <= nxt_creset;
        end
    end

    assign trigger_output_pin_o = trig_ff;
    assign trace_valid_o = tvalid_ff;
    assign trace_data_o = tdata_ff;
    assign halted_o = halted_ff;
    assign chip_reset_o = creset_ff;
    assign wdg_on_o = wdg_on;
    // Only selects the source; the clock mux itself sits on the board
    assign clk_ext_sel_o = ctrl_ff.clk_ext;

    // ------------------------------------------------------------
    // Timers A, B and the PWM unit
    // ------------------------------------------------------------
    logic freeze;
    assign freeze = halted_ff || break_i;

    for (genvar g = 0; g < etec_pkg::NTMR; g++) begin : g_tmr
        logic ext_e, cap_l;
        assign ext_e = (g == etec_pkg::TMR_A) ? ta_edge : 1'b0;
        assign cap_l = (g == 0) ? sync2_ff.cap_a
                     : (g == 1) ? sync2_ff.cap_b : 1'b0;
        etec_timer #(
            .W(etec_pkg::TW),
            .PW(etec_pkg::PRESC_W)
        ) u_tmr (
            .clk_i(clk_i),
            .reset_i(reset_i),
            .run_i(!freeze || ctrl_ff.run[g]),
            .presc_i(presc_ff[g][etec_pkg::PRESC_W-1:0]),
            .ext_sel_i(presc_ff[g][etec_pkg::PRESC_EXT_BIT]),
            .ext_edge_i(ext_e),
            .cap_lvl_i(cap_l),
            .cmp_i(cmp_ff[g]),
            .cnt_o(cnt_w[g]),
            .cap_o(cap_w[g]),
            .match_o(tmr_match_o[g]),
            .pwm_o(tmr_pwm_o[g])
        );
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    halt_trigger_input_pin_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        ctrl_ff.brk_trig && trig_rise && instr_done_i |=> halted_ff)
        else $error("trigger edge did not halt");
    trig_hit_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        ctrl_ff.hit_mode |=> trig_ff == $past(hit_acc))
        else $error("hit trigger mismatch");
    win_open_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !ctrl_ff.hit_mode && open_acc |=> trig_ff && win_ff)
        else $error("window did not open");
    win_close_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !ctrl_ff.hit_mode && close_acc && !open_acc |=> !trig_ff)
        else $error("window did not close");
    win_hold_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !ctrl_ff.hit_mode && !nxt_ctrl.hit_mode && win_ff && !close_acc
        |=> trig_ff && win_ff)
        else $error("window dropped early");
    trace_known_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        trace_valid_o |->
        trace_data_o.known == (trace_data_o.addr >= etec_pkg::ADDR_KNOWN))
        else $error("trace pin validity wrong");
    trace_filter_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        trace_valid_o && $past(ctrl_ff.filt_en) |-> $past(ev_active))
        else $error("filtered trace without event");
    ovf_break_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        ctrl_ff.brk_ovf && at_full |=> halted_ff && trace_full)
        else $error("overflow did not halt");
    halt_reset_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        halt_instr_i && wdg_on |=> chip_reset_o == $past(ctrl_ff.halt_rst))
        else $error("halt reset wrong");

endmodule

// ==== sim/etec_equip.sv ====
`timescale 1ns/10ps
module etec_equip (
    input wire logic clk_i,
    input wire logic fire_i,
    output logic trig_o,
    output logic [2:0] probe_o,
    output logic ta_clk_o
);
    // --------------------------------------------------
    // Pin drivers of the test equipment
    // --------------------------------------------------
    logic [3:0] div_ff = 4'h0;
    always_ff @(posedge clk_i) begin
        trig_o <= fire_i;
        div_ff <= div_ff + 4'h1;
    end
    // Divide by 16 keeps the timer clock under 16 MHz
    // Only the timer pin is clocked, never the oscillator input
    assign ta_clk_o = div_ff[3];
    assign probe_o = 3'h5;
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
    logic clk_i = 1'h0;
    logic reset_i = 1'h1;
    logic [7:0] adr = 8'h0;
    logic rd = 1'h0;
    logic wr = 1'h0;
    logic brk = 1'h0;
    logic fire = 1'h0;
    logic cacc = 1'h0;
    logic [2:0] pls = 3'h0;
    logic [15:0] caddr = 16'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, q, c1;
    logic wait_o, trig_pin, ta_clk, tout, tvalid, halted, creset;
    logic wdg_on, ext_sel;
    logic [2:0] probe, pwm, match;
    etec_pkg::etec_trace_t tdata;
    int failures = 0;
    int total_checks = 0;

    initial begin
        forever #2 clk_i = ~clk_i;
    end

    etec_core #(.DEPTH(4)) uut (
        .clk_i(clk_i), .reset_i(reset_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
        .avs_byteenable_i(4'hf), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wait_o), .cpu_addr_i(caddr),
        .cpu_access_i(cacc), .instr_done_i(pls[0]),
        .halt_instr_i(pls[1]), .wdg_sw_enable_i(pls[2]),
        .break_i(brk), .trigger_input_pin_i(trig_pin),
        .probe_i(probe), .timer_a_external_clock_i(ta_clk),
        .capture_i(2'h0), .trigger_output_pin_o(tout),
        .trace_valid_o(tvalid), .trace_data_o(tdata),
        .halted_o(halted), .chip_reset_o(creset), .wdg_on_o(wdg_on),
        .clk_ext_sel_o(ext_sel), .tmr_pwm_o(pwm), .tmr_match_o(match)
    );

    etec_equip equip (
        .clk_i(clk_i), .fire_i(fire), .trig_o(trig_pin),
        .probe_o(probe), .ta_clk_o(ta_clk)
    );

    // --------------------------------------------------
    // Access tasks
    // --------------------------------------------------
    task automatic cmp(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Holds the request until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_i);
        adr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        // Look mid-cycle, where the combinational waitrequest has settled
        do @(negedge clk_i); while (wait_o !== 1'h0);
        @(posedge clk_i);
        q = rdat;
        wr <= 1'h0;
        rd <= 1'h0;
    endtask

    // Returns mid-cycle, while the registered answer to the access stands
    task automatic cpu(input logic [15:0] a);
        @(posedge clk_i);
        caddr <= a;
        cacc <= 1'h1;
        @(posedge clk_i);
        cacc <= 1'h0;
        @(negedge clk_i);
    endtask

    task automatic pulse(input logic [2:0] p);
        @(posedge clk_i);
        pls <= p;
        @(posedge clk_i);
        pls <= 3'h0;
        @(negedge clk_i);
    endtask

    task automatic tally_and_finish;
        if (failures == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        tally_and_finish;
    end

    // --------------------------------------------------
    // Tests
    // --------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_i);
        reset_i <= 1'h0;
        cmp("trig_rst", 32'h0, tout);
        bus(1'h0, etec_pkg::OFS_CTRL, 32'h0);
        cmp("ctrl_rst", 32'h0, q);
        bus(1'h1, etec_pkg::OFS_CTRL, 32'h201);
        bus(1'h0, etec_pkg::OFS_CTRL, 32'h0);
        cmp("ctrl", 32'h201, q);
        cmp("ext_sel", 32'h1, ext_sel);
        bus(1'h1, 8'h80, 32'hffff);
        bus(1'h0, 8'h80, 32'h0);
        cmp("unmapped", 32'h0, q);
        bus(1'h1, etec_pkg::OFS_HIT, 32'h2345);
        cpu(16'h2345);
        cmp("hit_on", 32'h1, tout);
        cmp("trace_v", 32'h1, tvalid);
        cmp("trace_hi", {11'h0, 1'h1, 4'h5, 16'h2345}, tdata);
        @(negedge clk_i);
        cmp("hit_off", 32'h0, tout);
        cpu(16'h1000);
        cmp("miss", 32'h0, tout);
        cmp("trace_lo", {11'h0, 1'h0, 4'hf, 16'h1000}, tdata);
        bus(1'h1, etec_pkg::OFS_CTRL, 32'h3);
        cpu(16'h1000);
        cmp("filt_miss", 32'h0, tvalid);
        cpu(16'h2345);
        cmp("filt_hit", 32'h1, tvalid);
        bus(1'h1, etec_pkg::OFS_OPEN, 32'h3000);
        bus(1'h1, etec_pkg::OFS_CLOSE, 32'h3010);
        bus(1'h1, etec_pkg::OFS_CTRL, 32'h0);
        cpu(16'h3000);
        cpu(16'h3004);
        cmp("win_open", 32'h1, tout);
        cpu(16'h3010);
        cmp("win_close", 32'h0, tout);
        cpu(16'h2345);
        cmp("win_hit", 32'h0, tout);
        bus(1'h1, etec_pkg::OFS_CTRL, 32'h4);
        fire <= 1'h1;
        repeat (8) @(posedge clk_i);
        cmp("wait_instr", 32'h0, halted);
        pulse(3'h1);
        cmp("trig_halt", 32'h1, halted);
        fire <= 1'h0;
        bus(1'h1, etec_pkg::OFS_CMD, 32'h3);
        @(posedge clk_i);
        cmp("resume", 32'h0, halted);
        bus(1'h1, etec_pkg::OFS_CTRL, 32'h8);
        repeat (3) cpu(16'h1000);
        cmp("ovf_3", 32'h0, halted);
        cpu(16'h1000);
        @(posedge clk_i);
        cmp("ovf_4", 32'h1, halted);
        bus(1'h0, etec_pkg::OFS_STATUS, 32'h0);
        cmp("status_full", 32'h14, q);
        bus(1'h1, etec_pkg::OFS_CMD, 32'h3);
        bus(1'h1, etec_pkg::OFS_CTRL, 32'h180);
        @(negedge clk_i);
        cmp("wdg_hw", 32'h1, wdg_on);
        pulse(3'h2);
        cmp("halt_rst", 32'h1, creset);
        bus(1'h1, etec_pkg::OFS_CTRL, 32'h80);
        pulse(3'h2);
        cmp("no_rst", 32'h0, creset);
        bus(1'h1, etec_pkg::OFS_CTRL, 32'h100);
        @(negedge clk_i);
        cmp("wdg_off", 32'h0, wdg_on);
        pulse(3'h4);
        cmp("wdg_sw", 32'h1, wdg_on);
        pulse(3'h2);
        cmp("sw_rst", 32'h1, creset);
        bus(1'h1, etec_pkg::OFS_CTRL, 32'h40);
        brk <= 1'h1;
        bus(1'h0, 8'h28, 32'h0);
        c1 = q;
        bus(1'h0, 8'h28, 32'h0);
        cmp("a_frozen", c1, q);
        bus(1'h0, 8'h48, 32'h0);
        c1 = q;
        bus(1'h0, 8'h48, 32'h0);
        cmp("pwm_runs", 32'h1, {31'h0, q !== c1});
        brk <= 1'h0;
        bus(1'h0, 8'h28, 32'h0);
        c1 = q;
        bus(1'h0, 8'h28, 32'h0);
        cmp("a_runs", 32'h1, {31'h0, q !== c1});
        bus(1'h1, 8'h44, 32'hffff);
        repeat (2) @(negedge clk_i);
        cmp("pwm_out", 32'h4, pwm);
        tally_and_finish;
    end
endmodule
